// ===== shared/rcr_params.svh
// Offsets, field positions, reset values and timing counts of the regulator control bank
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// Register indices; byte address is four times the index
`define RCR_IDX_REG9 10'h02E
`define RCR_IDX_RSVD 10'h02F
`define RCR_IDX_REG11 10'h030
`define RCR_IDX_VIB 10'h031
`define RCR_IDX_SEL1 10'h032
`define RCR_IDX_SEL2 10'h033
`define RCR_IDX_FIRST 10'h02E
`define RCR_IDX_LAST 10'h033

// Storage slots, index minus the first index
`define RCR_NUM_REGS 6
`define RCR_SLOT_REG9 3'h0
`define RCR_SLOT_REG11 3'h2
`define RCR_SLOT_VIB 3'h3
`define RCR_SLOT_SEL1 3'h4
`define RCR_SLOT_SEL2 3'h5

// Reset value of every word
`define RCR_RST_WORD 8'h00

// Regulator control word fields
`define RCR_BIT_SEQ 7
`define RCR_FLD_VSRC 6:5
`define RCR_BIT_VSEL 4
`define RCR_BIT_PDOFF 3
`define RCR_FLD_ENSRC 2:1
`define RCR_BIT_ON 0

// Pin source codes
`define RCR_SRC_NONE 2'h0
`define RCR_SRC_GPIO1 2'h1
`define RCR_SRC_GPIO2 2'h2
`define RCR_SRC_GPIO13 2'h3

// Vibration field and drive timing
`define RCR_FLD_VIB 5:0
`define RCR_VIB_OFF 6'h00
`define RCR_VIB_LAST_STEP 6'h3E
`define RCR_VIB_DIV_LAST 4'h3
// Bridge state at reset: low side on, high side off, code zero (brake)
`define RCR_VIB_RST 8'h80

// Voltage select word fields
`define RCR_BIT_REG3 7
`define RCR_BIT_PERIPH 4
`define RCR_BIT_MEMORY 3
`define RCR_BIT_PROC 2
`define RCR_BIT_CORE2 1
`define RCR_BIT_CORE1 0
`define RCR_BIT_IO 0

`endif

// ===== shared/rcr_pkg.sv
// Types shared by the regulator control bank
package rcr_pkg;

    // Drive state of one linear regulator
    typedef struct packed {
        logic seq_target;
        logic on;
        logic volt_b;
        logic pulldown_en;
    } rcr_ldo_t;

    // Dynamic voltage choices, 1 selects setting B
    typedef struct packed {
        logic reg3_volt_choice;
        logic periph_buck_volt_choice;
        logic memory_buck_volt_choice;
        logic processor_buck_volt_choice;
        logic core2_buck_volt_choice;
        logic core1_buck_volt_choice;
        logic io_buck_volt_choice;
    } rcr_bucks_t;

    // Vibration motor bridge drive
    typedef struct packed {
        logic low_side_on;
        logic high_side_on;
        logic [5:0] vibration_level_code;
    } rcr_vib_t;

endpackage

// ===== rtl/rcr_pin_event.sv
// Pin transition detector for one regulator's enable and voltage sources
`timescale 1ns/1ps
`default_nettype none
`include "rcr_params.svh"

module rcr_pin_event (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] pins_sync,
    input wire logic [1:0] en_src,
    input wire logic [1:0] volt_src,
    output logic en_set,
    output logic en_clr,
    output logic sel_a,
    output logic sel_b
);

    logic [2:0] pins_prev_ff;

    // Picks the pin named by a source code; code 00 names none
    function automatic logic pick(input logic [2:0] p, input logic [1:0] src);
        case (src)
            `RCR_SRC_GPIO1: pick = p[0];
            `RCR_SRC_GPIO2: pick = p[1];
            `RCR_SRC_GPIO13: pick = p[2];
            default: pick = 1'b0;
        endcase
    endfunction

    // Previous pin levels; same source picks both so a source change makes no edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pins_prev_ff <= 3'h0;
        end else begin
            pins_prev_ff <= pins_sync;
        end
    end

    wire en_now = pick(pins_sync, en_src);
    wire en_was = pick(pins_prev_ff, en_src);
    wire v_now = pick(pins_sync, volt_src);
    wire v_was = pick(pins_prev_ff, volt_src);

    // Passive to active turns on, active to passive turns off
    assign en_set = en_now & ~en_was; // R6
    assign en_clr = ~en_now & en_was; // R6
    // Passive to active picks A, active to passive picks B
    assign sel_a = v_now & ~v_was; // R3
    assign sel_b = ~v_now & v_was; // R3

endmodule

`default_nettype wire

// ===== rtl/rcr_regs.sv
// APB register bank for regulator, vibration and dynamic voltage control
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_params.svh"

// Functional notes
// R1 - Regulator 9 word; bit 7 sequencer target
// R2 - Pin source codes: none, GPIO1, GPIO2, GPIO13
// R3 - Voltage pin edges pick A or B
// R4 - Bit 4 picks voltage A or B
// R5 - Bit 3 low enables pull-down when off
// R6 - Enable pin edges switch regulator on/off
// R7 - Bit 0 switches regulator on or off
// R8 - Regulator 11 word, same layout as 9
// R9 - Vibration code zero brakes the motor
// R10 - Vibration level linear in 63 steps
// R11 - Select word one bit 7: regulator 3
// R12 - Select word one low bits: five bucks
// R13 - Select word two bit 0: I/O buck
// R14 - Reserved bits stored, never steer outputs

module rcr_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gpio1,
    input wire logic gpio2,
    input wire logic gpio13,
    output rcr_pkg::rcr_ldo_t reg9,
    output rcr_pkg::rcr_ldo_t reg11,
    output rcr_pkg::rcr_bucks_t bucks,
    output rcr_pkg::rcr_vib_t vibration_level
);

    // Register storage, one byte per slot
    logic [7:0] regs_ff [0:`RCR_NUM_REGS-1];
    logic [7:0] nxt_regs [0:`RCR_NUM_REGS-1];

    // Bus answer state
    logic [7:0] rdata_ff;
    logic err_ff;

    // Pin synchronisers
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;

    // Vibration drive state
    logic [3:0] vib_div_ff;
    logic [5:0] vib_step_ff;
    rcr_pkg::rcr_vib_t vib_ff;

    // Hardware events from the pin detectors, one per regulator
    logic [1:0] ev_en_set;
    logic [1:0] ev_en_clr;
    logic [1:0] ev_sel_a;
    logic [1:0] ev_sel_b;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Word index and its range check
    wire [9:0] acc_idx = paddr[11:2];
    wire acc_aligned = (paddr[1:0] == 2'h0);
    wire acc_in_range = (acc_idx >= `RCR_IDX_FIRST) && (acc_idx <= `RCR_IDX_LAST);
    wire acc_hit = acc_aligned && acc_in_range;
    wire [9:0] acc_off = acc_idx - `RCR_IDX_FIRST;
    wire [2:0] acc_slot = acc_off[2:0];

    // Setup cycle captures read data; access cycle commits writes
    wire setup_cyc = psel && !penable;
    wire access_cyc = psel && penable;
    wire wr_commit = access_cyc && pwrite && acc_hit;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------

    // Two flops per pin before any logic looks at the level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta_ff <= 3'h0;
            pin_sync_ff <= 3'h0;
        end else begin
            pin_meta_ff <= {gpio13, gpio2, gpio1};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Pin transition detectors, one per linear regulator
    // ------------------------------------------------------------

    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_ldo
            localparam logic [2:0] SLOT = (k == 0) ? `RCR_SLOT_REG9 : `RCR_SLOT_REG11;

            // Sources named by the stored control word
            wire [1:0] en_src = regs_ff[SLOT][`RCR_FLD_ENSRC]; // R2
            wire [1:0] volt_src = regs_ff[SLOT][`RCR_FLD_VSRC]; // R2

            rcr_pin_event u_pin_event (
                .clk_sys(clk_sys),
                .rst(rst),
                .pins_sync(pin_sync_ff),
                .en_src(en_src),
                .volt_src(volt_src),
                .en_set(ev_en_set[k]),
                .en_clr(ev_en_clr[k]),
                .sel_a(ev_sel_a[k]),
                .sel_b(ev_sel_b[k])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next register values
    // ------------------------------------------------------------

    // Overlays pin events on a control word; a pin event beats a
    // software write to the same bit in the same cycle
    function automatic logic [7:0] apply_pins(
        input logic [7:0] val,
        input logic en_set,
        input logic en_clr,
        input logic sel_a,
        input logic sel_b
    );
        logic [7:0] res;
        res = val;
        if (en_set) begin
            res[`RCR_BIT_ON] = 1'b1;
        end else if (en_clr) begin
            res[`RCR_BIT_ON] = 1'b0;
        end
        if (sel_a) begin
            res[`RCR_BIT_VSEL] = 1'b0;
        end else if (sel_b) begin
            res[`RCR_BIT_VSEL] = 1'b1;
        end
        apply_pins = res;
    endfunction

    genvar i;
    generate
        for (i = 0; i < `RCR_NUM_REGS; i = i + 1) begin : g_slot
            localparam logic [2:0] SLOT = 3'(i);
            localparam int K = (SLOT == `RCR_SLOT_REG11) ? 1 : 0;
            localparam bit IS_LDO = (SLOT == `RCR_SLOT_REG9) || (SLOT == `RCR_SLOT_REG11);

            // Every bit, reserved ones included, is stored as written, except a regulator word bit 0 or 4 that a same-cycle pin event sets or clears
            wire sw_wr = wr_commit && (acc_slot == SLOT); // R14
            wire [7:0] sw_val = sw_wr ? pwdata[7:0] : regs_ff[i];

            if (IS_LDO) begin : g_ldo_next
                // Pin edges drive the enable and voltage bits
                assign nxt_regs[i] = apply_pins(sw_val, ev_en_set[K], ev_en_clr[K],
                                                ev_sel_a[K], ev_sel_b[K]); // R3 R6
            end else begin : g_plain_next
                assign nxt_regs[i] = sw_val;
            end

            // Storage flop for this slot
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    regs_ff[i] <= `RCR_RST_WORD;
                end else begin
                    regs_ff[i] <= nxt_regs[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------

    // Read data and error are captured in the setup cycle
    wire [7:0] rd_mux = acc_hit ? regs_ff[acc_slot] : 8'h00;
    wire [7:0] nxt_rdata = setup_cyc ? rd_mux : rdata_ff;
    wire nxt_err = setup_cyc ? !acc_hit : err_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_ff <= 8'h00;
            err_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    // No wait states; upper data bits read as zero
    assign pready = 1'b1;
    assign prdata = {24'h000000, rdata_ff};
    assign pslverr = access_cyc && err_ff;

    // ------------------------------------------------------------
    // Linear regulator outputs
    // ------------------------------------------------------------

    // Regulator 9 word fields
    wire [7:0] w9 = regs_ff[`RCR_SLOT_REG9];
    assign reg9.seq_target = w9[`RCR_BIT_SEQ]; // R1
    assign reg9.on = w9[`RCR_BIT_ON]; // R7
    assign reg9.volt_b = w9[`RCR_BIT_VSEL]; // R4
    // Pull-down only while the regulator is off and not suppressed
    assign reg9.pulldown_en = !w9[`RCR_BIT_PDOFF] && !w9[`RCR_BIT_ON]; // R5

    // Regulator 11 word, same layout
    wire [7:0] w11 = regs_ff[`RCR_SLOT_REG11];
    assign reg11.seq_target = w11[`RCR_BIT_SEQ]; // R8
    assign reg11.on = w11[`RCR_BIT_ON]; // R8 R7
    assign reg11.volt_b = w11[`RCR_BIT_VSEL]; // R8 R4
    assign reg11.pulldown_en = !w11[`RCR_BIT_PDOFF] && !w11[`RCR_BIT_ON]; // R8 R5

    // ------------------------------------------------------------
    // Dynamic voltage choices; reserved bits are left out
    // ------------------------------------------------------------

    wire [7:0] s1 = regs_ff[`RCR_SLOT_SEL1];
    wire [7:0] s2 = regs_ff[`RCR_SLOT_SEL2];
    assign bucks.reg3_volt_choice = s1[`RCR_BIT_REG3]; // R11
    assign bucks.periph_buck_volt_choice = s1[`RCR_BIT_PERIPH]; // R12
    assign bucks.memory_buck_volt_choice = s1[`RCR_BIT_MEMORY]; // R12
    assign bucks.processor_buck_volt_choice = s1[`RCR_BIT_PROC]; // R12
    assign bucks.core2_buck_volt_choice = s1[`RCR_BIT_CORE2]; // R12
    assign bucks.core1_buck_volt_choice = s1[`RCR_BIT_CORE1]; // R12
    assign bucks.io_buck_volt_choice = s2[`RCR_BIT_IO]; // R13

    // ------------------------------------------------------------
    // Vibration drive
    // ------------------------------------------------------------

    // Level code; bits 7:6 are stored but never drive the bridge
    wire [5:0] vib_code = regs_ff[`RCR_SLOT_VIB][`RCR_FLD_VIB]; // R9 R14

    // Step enable from a divider of the system clock
    wire vib_tick = (vib_div_ff == `RCR_VIB_DIV_LAST);
    wire [3:0] nxt_vib_div = vib_tick ? 4'h0 : vib_div_ff + 4'h1;

    // Step counter runs 0..62, one PWM period of 63 steps
    wire vib_wrap = (vib_step_ff == `RCR_VIB_LAST_STEP);
    wire [5:0] vib_step_inc = vib_wrap ? 6'h00 : vib_step_ff + 6'h01;
    wire [5:0] nxt_vib_step = vib_tick ? vib_step_inc : vib_step_ff;

    // High side on for code steps out of 63, so average is code*3V/63
    wire vib_brake = (vib_code == `RCR_VIB_OFF); // R9
    wire vib_pwm_hi = (vib_step_ff < vib_code); // R10

    // Brake: low side on, high side off; else complementary drive
    rcr_pkg::rcr_vib_t nxt_vib;
    assign nxt_vib.high_side_on = !vib_brake && vib_pwm_hi; // R9 R10
    assign nxt_vib.low_side_on = vib_brake || !vib_pwm_hi; // R9
    assign nxt_vib.vibration_level_code = vib_code;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vib_div_ff <= 4'h0;
            vib_step_ff <= 6'h00;
            vib_ff <= `RCR_VIB_RST; // R9
        end else begin
            vib_div_ff <= nxt_vib_div;
            vib_step_ff <= nxt_vib_step;
            vib_ff <= nxt_vib;
        end
    end

    assign vibration_level = vib_ff;

endmodule

`default_nettype wire

// ===== test/rcr_regs_chk.sv
// Port-level checks for the regulator control bank
`timescale 1ns/1ps
`default_nettype none
`include "rcr_params.svh"

module rcr_regs_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic gpio1,
    input wire logic gpio2,
    input wire logic gpio13,
    input wire rcr_pkg::rcr_ldo_t reg9,
    input wire rcr_pkg::rcr_ldo_t reg11,
    input wire rcr_pkg::rcr_bucks_t bucks,
    input wire rcr_pkg::rcr_vib_t vibration_level
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Committed writes; regulator words only with both pin sources at none
    wire logic acc = psel && penable && pwrite;
    wire logic no_src = pwdata[6:5] == 2'h0 && pwdata[2:1] == 2'h0;
    wire logic wr9 = acc && no_src && paddr == {`RCR_IDX_REG9, 2'h0};
    wire logic wr11 = acc && no_src && paddr == {`RCR_IDX_REG11, 2'h0};
    wire logic wrs1 = acc && paddr == {`RCR_IDX_SEL1, 2'h0};
    wire logic wrs2 = acc && paddr == {`RCR_IDX_SEL2, 2'h0};
    wire logic wrrs = acc && paddr == {`RCR_IDX_RSVD, 2'h0};
    wire logic bad = paddr[1:0] != 2'h0 || paddr[11:2] < `RCR_IDX_FIRST
        || paddr[11:2] > `RCR_IDX_LAST;

    a_reg9_fields: assert property (wr9 |=> reg9 == {$past(pwdata[7]), $past(pwdata[0]),
        $past(pwdata[4]), !$past(pwdata[3]) && !$past(pwdata[0]) }) else $error("reg9 fields");
    a_reg11_fields: assert property (wr11 |=> reg11 == {$past(pwdata[7]), $past(pwdata[0]),
        $past(pwdata[4]), !$past(pwdata[3]) && !$past(pwdata[0]) }) else $error("reg11 fields");
    a_sel_one: assert property (wrs1 |=> bucks[6:1] == {$past(pwdata[7]), $past(pwdata[4:0])})
        else $error("select one");
    a_sel_two: assert property (wrs2 |=> bucks[0] == $past(pwdata[0]))
        else $error("select two");
    a_rsvd_quiet: assert property (wrrs |=> $stable(reg9) && $stable(reg11) && $stable(bucks))
        else $error("reserved word moved outputs");
    a_vib_brake: assert property (vibration_level.vibration_level_code == `RCR_VIB_OFF
        |-> vibration_level.low_side_on && !vibration_level.high_side_on) else $error("no brake at code zero");
    a_vib_bridge: assert property (vibration_level.low_side_on != vibration_level.high_side_on)
        else $error("bridge switches not complementary");
    a_bad_addr: assert property (psel && penable && bad |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access");
endmodule
`default_nettype wire

// ===== test/regulator_control_regs_bench.sv
// Self-checking bench for the regulator control bank
`timescale 1ns/1ps
`default_nettype none
`include "rcr_params.svh"

module regulator_control_regs_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic gpio1 = 1'b0;
    logic gpio2 = 1'b0;
    logic gpio13 = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rcr_pkg::rcr_ldo_t reg9;
    rcr_pkg::rcr_ldo_t reg11;
    rcr_pkg::rcr_bucks_t bucks;
    rcr_pkg::rcr_vib_t vibration_level;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] rd_q;
    logic rd_e;
    // Enable and voltage choice of both linear regulators
    wire [3:0] ldo_st = {reg9.on, reg9.volt_b, reg11.on, reg11.volt_b};

    // 20 MHz clock
    always #25 clk_sys = ~clk_sys;

    rcr_regs uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpio1(gpio1), .gpio2(gpio2), .gpio13(gpio13), .reg9(reg9),
        .reg11(reg11), .bucks(bucks), .vibration_level(vibration_level));

    // Verdict and end of run
    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; upper data bits set to show they are ignored
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [1:0] lo,
        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, lo};
        pwdata <= {24'hFFFFFF, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                wrap_up();
            end
            @(posedge clk_sys);
        end
        rd_q = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic set_pin(input int code, input logic v);
        case (code)
            1: gpio1 <= v;
            2: gpio2 <= v;
            default: gpio13 <= v;
        endcase
    endtask

    // Reset state of every word, of reg9 and of the vibration drive
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, `RCR_IDX_FIRST + 10'(i), 2'h0, 8'h00);
            check(rd_q, 32'h0, "reset word");
        end
        check(32'(reg9), 32'h1, "reg9 reset");
        check(32'(vibration_level), 32'h80, "brake at reset");
    endtask

    // Write every word, read back, then look at the outputs
    task automatic t_rw();
        logic [7:0] d [6] = '{8'h99, 8'hA5, 8'h81, 8'hFF, 8'hFF, 8'hFF};
        for (int i = 0; i < 6; i++) apb(1'b1, `RCR_IDX_FIRST + 10'(i), 2'h0, d[i]);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, `RCR_IDX_FIRST + 10'(i), 2'h0, 8'h00);
            check(rd_q, 32'(d[i]), "readback");
        end
        check(32'(reg9), 32'hE, "reg9 word");
        check(32'(reg11), 32'hC, "reg11 word");
        check(32'(bucks), 32'h7F, "all select B");
        check(32'(vibration_level.vibration_level_code), 32'h3F, "vib code");
    endtask

    // Pull-down and enable bits of regulator 9
    task automatic t_pd();
        logic [7:0] d [4] = '{8'h00, 8'h08, 8'h01, 8'h10};
        logic [3:0] e [4] = '{4'h1, 4'h0, 4'h4, 4'h3};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `RCR_IDX_REG9, 2'h0, d[i]);
            wait_n(1);
            check(32'(reg9), 32'(e[i]), "pull-down and enable");
        end
    endtask

    // Each select bit on its own, reserved bits drive nothing
    task automatic t_bucks();
        logic [6:0] e;
        apb(1'b1, `RCR_IDX_SEL2, 2'h0, 8'h00);
        for (int b = 0; b < 8; b++) begin
            e = (b == 7) ? 7'h40 : (b < 5) ? 7'(7'h02 << b) : 7'h00;
            apb(1'b1, `RCR_IDX_SEL1, 2'h0, 8'(8'h01 << b));
            wait_n(1);
            check(32'(bucks), 32'(e), "select one bit");
        end
        apb(1'b1, `RCR_IDX_SEL1, 2'h0, 8'h00);
        apb(1'b1, `RCR_IDX_SEL2, 2'h0, 8'hFE);
        wait_n(1);
        check(32'(bucks), 32'h0, "select two reserved");
        apb(1'b1, `RCR_IDX_SEL2, 2'h0, 8'h01);
        wait_n(1);
        check(32'(bucks), 32'h1, "select two bit");
    endtask

    // Unmapped and misaligned accesses are refused
    task automatic t_bad();
        apb(1'b0, 10'h02D, 2'h0, 8'h00);
        check({rd_q[30:0], rd_e}, 32'h1, "below map");
        apb(1'b1, `RCR_IDX_REG9, 2'h1, 8'hFF);
        check(32'(rd_e), 32'h1, "misaligned");
        apb(1'b0, `RCR_IDX_REG9, 2'h0, 8'h00);
        check(rd_q, 32'h10, "misaligned write kept out");
        apb(1'b0, 10'h034, 2'h0, 8'h00);
        check({rd_q[30:0], rd_e}, 32'h1, "above map");
    endtask

    // Pin events for the GPIO1, GPIO2 and GPIO13 source codes; an unselected pin is ignored
    task automatic t_pins();
        logic [7:0] w;
        for (int c = 1; c < 4; c++) begin
            w = {1'b0, 2'(c), 1'b1, 1'b0, 2'(c), 1'b0};
            apb(1'b1, `RCR_IDX_REG9, 2'h0, w);
            apb(1'b1, `RCR_IDX_REG11, 2'h0, w);
            set_pin(c % 3 + 1, 1'b1);
            wait_n(7);
            check(32'(ldo_st), 32'h5, "other pin ignored");
            set_pin(c % 3 + 1, 1'b0);
            set_pin(c, 1'b1);
            wait_n(7);
            check(32'(ldo_st), 32'hA, "pin rise");
            set_pin(c, 1'b0);
            wait_n(7);
            check(32'(ldo_st), 32'h5, "pin fall");
        end
    endtask

    // Mid-run reset returns the reg9 word, reg9 and the vibration drive to their reset state
    task automatic t_rst2();
        apb(1'b1, `RCR_IDX_REG9, 2'h0, 8'h99);
        rst <= 1'b1;
        wait_n(3);
        rst <= 1'b0;
        wait_n(1);
        check(32'(reg9), 32'h1, "reg9 after reset");
        check(32'(vibration_level), 32'h80, "brake after reset");
        apb(1'b0, `RCR_IDX_REG9, 2'h0, 8'h00);
        check(rd_q, 32'h0, "reg9 word after reset");
    endtask

    // Vibration drive duty over one full period of 252 clocks
    task automatic t_vib();
        logic [5:0] d [4] = '{6'h00, 6'h01, 6'h20, 6'h3F};
        int hi;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `RCR_IDX_VIB, 2'h0, {2'h0, d[i]});
            wait_n(260);
            hi = 0;
            repeat (252) begin
                @(posedge clk_sys);
                if (vibration_level.high_side_on === 1'b1) hi++;
            end
            check(32'(hi), 32'(d[i]) * 4, "vib duty");
        end
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_rw();
        t_pd();
        t_bucks();
        t_bad();
        t_pins();
        t_vib();
        t_rst2();
        wrap_up();
    end
endmodule

bind rcr_regs rcr_regs_chk chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gpio1(gpio1), .gpio2(gpio2), .gpio13(gpio13),
    .reg9(reg9), .reg11(reg11), .bucks(bucks), .vibration_level(vibration_level));
`default_nettype wire
